// ==== design/fault_status_registers.v ====
// Read-only power-stage and controller fault status registers
`timescale 1ns/1ns
`include "fault_status_map.vh"

// Behaviour
// - Power-stage bit 31 is OR of all its flags; fault pin mirrors it, low.
// - Bit 30 reads one while a step-down regulator fault is latched.
// - Bit 28 reads one when any switch overcurrent is latched.
// - Bit 26 reads one when motor supply overvoltage is latched.
// - Bit 25 is set when thermal warning or thermal shutdown is latched.
// - Bit 23 reports thermal warning.
// - Bit 22 reports thermal shutdown.
// - Bits 21..16: C high, C low, B high, B low, A high, A low overcurrent.
// - Bit 14 reports one-time memory error.
// - Bit 13 reports step-down regulator overcurrent.
// - Bit 12 reports step-down regulator undervoltage.
// - Bit 11 reports charge pump undervoltage.
// - Controller fault register at E2h, read-only, zero after reset.
// - Power-stage fault register at E0h, zero after reset.
// - Controller bit 31 is OR of all controller fault flags.
module fault_status_registers
(
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // Fault detectors, level while the condition lasts
  input  wire        step_down_reg_error,
  input  wire        supply_overvolt_flag,
  input  wire        thermal_warning_flag,
  input  wire        thermal_shutdown_flag,
  input  wire [5:0]  switch_overcurrent,
  input  wire        otp_error,
  input  wire        step_down_overcurrent,
  input  wire        step_down_undervolt,
  input  wire        charge_pump_undervolt,
  input  wire [31:0] controller_fault_in,
  // Fault clear, one-cycle pulse
  input  wire        fault_clear,
  // Register read port
  input  wire        rd_en,
  input  wire [7:0]  rd_addr,
  // Register write port, accepted and ignored
  input  wire        wr_en,
  input  wire [7:0]  wr_addr,
  input  wire [31:0] wr_data,
  output reg  [31:0] rd_data,
  output reg         rd_valid,
  // Fault pin and register images
  output reg         error_indicator_pin_low,
  output reg  [31:0] power_stage_fault_flags,
  output reg  [31:0] controller_fault_flags
);

  // Next state of the two sticky banks
  wire [31:0] ps_nxt;
  wire [31:0] cf_nxt;
  // Raw fault events at their register positions
  reg  [31:0] ps_evt;
  wire [31:0] cf_evt;
  // Images with summary bits rebuilt
  reg  [31:0] ps_img;
  reg  [31:0] cf_img;
  // Read data ahead of its output register
  reg  [31:0] rd_data_nxt;
  // Write port has no effect
  wire        unused_wr;

  always @*
  begin
    ps_evt = 32'h00000000;
    ps_evt[`PS_STEP_DOWN_ERR_BIT] = step_down_reg_error;
    ps_evt[`PS_OVERVOLT_BIT] = supply_overvolt_flag;
    ps_evt[`PS_THERMAL_WARN_BIT] = thermal_warning_flag;
    ps_evt[`PS_THERMAL_SHUT_BIT] = thermal_shutdown_flag;
    ps_evt[`PS_SWITCH_OC_MSB:`PS_SWITCH_OC_LSB] = switch_overcurrent;
    ps_evt[`PS_OTP_ERR_BIT] = otp_error;
    ps_evt[`PS_STEP_DOWN_OC_BIT] = step_down_overcurrent;
    ps_evt[`PS_STEP_DOWN_UV_BIT] = step_down_undervolt;
    ps_evt[`PS_PUMP_UV_BIT] = charge_pump_undervolt;
  end

  // Reserved positions masked so stray detector bits never show
  assign cf_evt = controller_fault_in & `CF_FLAG_MASK;

  // Power-stage flags hold until a clear arrives with their detector low
  sticky_flags
  #(
    .WIDTH       (32),
    .RESET_VALUE (`RST_POWER_STAGE)
  )
  sticky_flags_inst
  (
    .clock     (clock),
    .rst       (rst),
    .clear     (fault_clear),
    .set       (ps_evt),
    .flags_nxt (ps_nxt)
  );

  // Controller flags use the same bank
  sticky_flags
  #(
    .WIDTH       (32),
    .RESET_VALUE (`RST_CONTROLLER)
  )
  sticky_flags_ctrl_inst
  (
    .clock     (clock),
    .rst       (rst),
    .clear     (fault_clear),
    .set       (cf_evt),
    .flags_nxt (cf_nxt)
  );

  // Summaries come from next state so image and pin agree in one cycle; read returns that image one cycle later
  always @*
  begin
    ps_img = ps_nxt;
    ps_img[`PS_OC_SUMMARY_BIT] = |ps_nxt[`PS_SWITCH_OC_MSB:`PS_SWITCH_OC_LSB];
    ps_img[`PS_THERMAL_ANY_BIT] = ps_nxt[`PS_THERMAL_WARN_BIT] |
                                  ps_nxt[`PS_THERMAL_SHUT_BIT];
    ps_img[`PS_SUMMARY_BIT] = |ps_nxt[30:0];
  end

  always @*
  begin
    cf_img = cf_nxt;
    cf_img[`CF_SUMMARY_BIT] = |cf_nxt[30:0];
  end

  // Read returns the image registered last cycle; writes have no path here
  always @*
  begin
    rd_data_nxt = 32'h00000000;
    if (rd_en)
    begin
      case (rd_addr)
        `OFS_POWER_STAGE:
          rd_data_nxt = power_stage_fault_flags;
        `OFS_CONTROLLER:
          rd_data_nxt = controller_fault_flags;
        default:
          rd_data_nxt = 32'h00000000;
      endcase
    end
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      power_stage_fault_flags <= `RST_POWER_STAGE;
      controller_fault_flags  <= `RST_CONTROLLER;
      error_indicator_pin_low <= 1'b1;
    end
    else
    begin
      power_stage_fault_flags <= ps_img;
      controller_fault_flags  <= cf_img;
      error_indicator_pin_low <= ~ps_img[`PS_SUMMARY_BIT];
    end
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_en;
    end
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      rd_data <= 32'h00000000;
    end
    else
    begin
      rd_data <= rd_data_nxt;
    end
  end

  // Write port accepted only so the host bus can be wired; contents never change
  assign unused_wr = wr_en & (|wr_addr) & (|wr_data);

endmodule

// Bank of sticky flags; a set in the clear cycle wins
module sticky_flags
#(
  parameter             WIDTH       = 32,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
)
(
  // Clock and reset
  input  wire             clock,
  input  wire             rst,
  // Clear pulse and set events
  input  wire             clear,
  input  wire [WIDTH-1:0] set,
  // Next state, so callers can build images without a cycle of lag
  output wire [WIDTH-1:0] flags_nxt
);

  reg  [WIDTH-1:0] flags_r;

  // A fault still present during clear stays set: set wins over clear
  assign flags_nxt = (clear ? {WIDTH{1'b0}} : flags_r) | set;

  always @(posedge clock)
  begin
    if (rst)
    begin
      flags_r <= RESET_VALUE;
    end
    else
    begin
      flags_r <= flags_nxt;
    end
  end

endmodule

// ==== design/fault_status_map.vh ====
// Offsets, field positions and reset values of the fault status registers
`ifndef FAULT_STATUS_MAP_VH
`define FAULT_STATUS_MAP_VH
`define OFS_POWER_STAGE      8'he0
`define OFS_CONTROLLER       8'he2
`define RST_POWER_STAGE      32'h00000000
`define RST_CONTROLLER       32'h00000000
`define PS_SUMMARY_BIT       31
`define PS_STEP_DOWN_ERR_BIT 30
`define PS_OC_SUMMARY_BIT    28
`define PS_OVERVOLT_BIT      26
`define PS_THERMAL_ANY_BIT   25
`define PS_THERMAL_WARN_BIT  23
`define PS_THERMAL_SHUT_BIT  22
`define PS_SWITCH_OC_MSB     21
`define PS_SWITCH_OC_LSB     16
`define PS_OTP_ERR_BIT       14
`define PS_STEP_DOWN_OC_BIT  13
`define PS_STEP_DOWN_UV_BIT  12
`define PS_PUMP_UV_BIT       11
`define CF_SUMMARY_BIT       31
`define CF_FLAG_MASK         32'h3fffc008
`endif

// ==== verification/fault_status_sva.sv ====
// Concurrent checks on the fault status register ports
`timescale 1ns/1ns
module fault_status_sva
(
  // Watched ports
  input wire        clock, rst, thermal_warning_flag, rd_en, rd_valid, error_indicator_pin_low,
  input wire [7:0]  rd_addr,
  input wire [31:0] rd_data, power_stage_fault_flags, controller_fault_flags
);
  wire [31:0] ps = power_stage_fault_flags;
  wire [31:0] cf = controller_fault_flags;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_rd; rd_en && rd_addr == 8'he0; endsequence
  sequence s_ans; rd_valid && rd_data == $past(ps); endsequence
  property p_pin; error_indicator_pin_low == !ps[31]; endproperty
  a_pin: assert property (p_pin) else $error("pin and summary differ");
  property p_sum; ps[31] == |ps[30:0]; endproperty
  a_sum: assert property (p_sum) else $error("summary wrong");
  property p_oc; ps[28] == |ps[21:16]; endproperty
  a_oc: assert property (p_oc) else $error("overcurrent summary wrong");
  property p_ot; ps[25] == (ps[23] | ps[22]); endproperty
  a_ot: assert property (p_ot) else $error("thermal summary wrong");
  property p_rsv; (ps & 32'h290087ff) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_cf; cf[31] == |cf[30:0]; endproperty
  a_cf: assert property (p_cf) else $error("controller summary wrong");
  property p_warn; thermal_warning_flag |=> ps[23] && ps[25]; endproperty
  a_warn: assert property (p_warn) else $error("warning not latched");
  property p_rd; s_rd |=> s_ans; endproperty
  a_rd: assert property (p_rd) else $error("read answer wrong");
endmodule
bind fault_status_registers fault_status_sva fault_status_sva_inst (.clock, .rst,
  .thermal_warning_flag, .rd_en, .rd_valid, .error_indicator_pin_low, .rd_addr,
  .rd_data, .power_stage_fault_flags, .controller_fault_flags);

// ==== verification/host_reader.sv ====
// Host model that reads the fault registers
`timescale 1ns/1ns
module host_reader
(
  // Read port
  input wire        clock, rd_valid,
  input wire [31:0] rd_data,
  output reg        rd_en = 1'b0,
  output reg [7:0]  rd_addr = 8'h00
);
  // Latency is fixed at one cycle, so no wait loop; address inverted once released
  task rd(input [7:0] a, output [31:0] d);
    @(posedge clock) #1 rd_en = 1'b1;
    rd_addr = a;
    @(posedge clock) #1 d = rd_valid === 1'b1 ? rd_data : 32'hx;
    rd_en = 1'b0;
    rd_addr = ~a;
  endtask
endmodule

// ==== verification/fault_status_registers_tb_top.sv ====
// Self-checking bench for the fault status registers
`timescale 1ns/1ns
module fault_status_registers_tb_top;
  reg         clock = 0, rst = 1, fault_clear = 0, wr_en = 0;
  reg  [13:0] det = 0;
  reg  [31:0] ctl = 0, d;
  wire        rd_en, rd_valid, pin;
  wire [7:0]  rd_addr;
  wire [31:0] rd_data, ps, cf;
  integer     num_errors = 0, samples_checked = 0, i;
  always #2 clock = ~clock;
  fault_status_registers fault_status_registers_inst (.clock(clock), .rst(rst),
    .step_down_reg_error(det[13]), .supply_overvolt_flag(det[12]),
    .thermal_warning_flag(det[11]), .thermal_shutdown_flag(det[10]),
    .switch_overcurrent(det[9:4]), .otp_error(det[3]), .step_down_overcurrent(det[2]),
    .step_down_undervolt(det[1]), .charge_pump_undervolt(det[0]), .controller_fault_in(ctl),
    .fault_clear(fault_clear), .rd_en(rd_en), .rd_addr(rd_addr), .wr_en(wr_en),
    .wr_addr(8'he2), .wr_data(32'hffffffff), .rd_data(rd_data), .rd_valid(rd_valid),
    .error_indicator_pin_low(pin), .power_stage_fault_flags(ps), .controller_fault_flags(cf));
  host_reader host_reader_inst (.clock(clock), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_en(rd_en), .rd_addr(rd_addr));
  task chk(input [31:0] got, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Detector i maps to its bit, then the three summaries are rebuilt
  function [31:0] ex(input integer i);
    ex = 32'h1 << (i > 3 ? (i == 13 ? 30 : i == 12 ? 26 : i + 12) : i + 11);
    ex[28] = |ex[21:16];
    ex[25] = ex[23] | ex[22];
    ex[31] = |ex;
  endfunction
  task pulse_clear;
    @(posedge clock) #1 fault_clear = 1;
    @(posedge clock) #1 fault_clear = 0;
  endtask
  task t_rst;
    host_reader_inst.rd(8'he0, d);
    chk(d, 32'h0);
    host_reader_inst.rd(8'he2, d);
    chk(d, 32'h0);
    chk({31'h0, pin}, 32'h1);
    $display("reset values done");
  endtask
  // Each detector pulses once and is read back after it has gone away
  task t_bits;
    for (i = 0; i < 14; i = i + 1)
    begin
      @(posedge clock) #1 det = 14'h1 << i;
      @(posedge clock) #1 det = 0;
      host_reader_inst.rd(8'he0, d);
      chk(d, ex(i));
      chk({31'h0, pin}, 32'h0);
      pulse_clear;
      chk(ps, 32'h0);
    end
    $display("power stage bits done");
  endtask
  task t_ctrl;
    @(posedge clock) #1 ctl = 32'hffffffff;
    wr_en = 1;
    @(posedge clock) #1 ctl = 0;
    wr_en = 0;
    host_reader_inst.rd(8'he2, d);
    chk(d, 32'hbfffc008);
    host_reader_inst.rd(8'he4, d);
    chk(d, 32'h0);
    pulse_clear;
    chk(cf, 32'h0);
    @(posedge clock) #1 wr_en = 1;
    @(posedge clock) #1 wr_en = 0;
    host_reader_inst.rd(8'he2, d);
    chk(d, 32'h0);
    $display("controller and writes done");
  endtask
  // Clear while the detector is still high, then a reset in mid-run
  task t_hold;
    @(posedge clock) #1 det = 14'h800;
    pulse_clear;
    det = 0;
    chk(ps, ex(11));
    @(posedge clock) #1 rst = 1;
    @(posedge clock) #1 rst = 0;
    chk(ps, 32'h0);
    chk({31'h0, pin}, 32'h1);
    $display("set over clear and reset done");
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clock);
    #1 rst = 0;
    t_rst;
    t_bits;
    t_ctrl;
    t_hold;
    report_and_stop;
  end
endmodule
